// [shared/vrt_pkg.sv]
// Purpose: constants for the closing ramp, travel total and limit alarm block
// Assumes: 10 MHz clock, positions in 0.1 % steps (0..1000)
// Notes: register offsets are word indices times four
package vrt_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_HZ = 1000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam logic [10:0] RANGE_FULL = 11'h3E8;
    localparam logic [7:0] CLOSE_TIME_MAX_S = 8'hF0;
    localparam logic [7:0] CLOSE_TIME_RST = 8'h00;
    localparam logic [10:0] LIM1_RST = 11'h014;
    localparam logic [10:0] LIM2_RST = 11'h3D4;
    localparam logic [10:0] CUTOFF_RST = 11'h00A;
    localparam logic [10:0] CUTOFF_MAX = 11'h1F3;
    localparam logic [1:0] ALARM_MODE_RST = 2'h2;
    localparam logic [31:0] TOTAL_MAX = 32'h3B02_3380;
    localparam logic [31:0] TOTAL_LIMIT_MIN = 32'h0000_03E8;
    localparam logic [31:0] TOTAL_LIMIT_RST = 32'h0000_03E8;
    localparam logic [9:0] SAVE_EVERY = 10'h3E8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLOSE_TIME = 8'h04;
    localparam logic [7:0] OFS_CUTOFF = 8'h08;
    localparam logic [7:0] OFS_LIM1 = 8'h0C;
    localparam logic [7:0] OFS_LIM2 = 8'h10;
    localparam logic [7:0] OFS_TOTAL = 8'h14;
    localparam logic [7:0] OFS_TOTAL_LIMIT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_SETPOINT = 8'h28;
    // ctrl bits
    localparam int CTRL_CLEAR = 0;
    localparam int CTRL_CUT_EN = 1;
    localparam int CTRL_LIM1_EN = 2;
    localparam int CTRL_LIM2_EN = 3;
    localparam int CTRL_MODE_LO = 4;
    // irq bits
    localparam int IRQ_SAVE = 0;
    localparam int IRQ_MAINT = 1;
    localparam int IRQ_FAULT = 2;
endpackage : vrt_pkg

// [logic/vrt_core.sv]
// Purpose: closing set-point ramp, travel cycle total, limit and fault alarms
// Assumes: position and set point in 0.1 % of operating range, single clock
// Notes: alarm outputs are logic levels, 1 = high current / conducting
//
// Behaviour
// R1 - closing time 0..240 s limits set-point fall over the full range
// R2 - closing ramp still governs when lower cutoff also active
// R3 - closing ramp bypassed on fail-safe, solenoid trip or power loss
// R4 - keep full travel cycle total, 0 up to 99e7, reset zero
// R5 - operator clear choice sets the total to zero
// R6 - save total to non-volatile store every 1000 added cycles
// R7 - settable total limit from 1000; maintenance flag while total exceeds it
// R8 - alarm mode 0..3 default 2 sets active level of both limit alarms
// R9 - same polarity selection drives conducting or non-conducting outputs
// R10 - fault alarm low when fault exists, high otherwise
// R11 - first limit 0..100 %, default 2 %, may be disabled, relative position
// R12 - second limit default 98 %, alarm when position below limit
// R13 - set point at cutoff near closed end drives actuator fully closed
// R14 - zero time means no limit, else range over time per tick step
`timescale 1ns/1ns
`default_nettype none
module vrt_core
    import vrt_pkg::*;
#(
    // clock cycles per ramp tick; the divider counter below is 14 bits wide
    parameter int TICK_CYCLES = TICK_DIV
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_ff,
    // process inputs
    input wire logic [10:0] setpoint_in,
    input wire logic [10:0] position_in,
    input wire logic cycle_done_pin,
    input wire logic failsafe_pin,
    input wire logic solenoid_pin,
    input wire logic power_fail_pin,
    input wire logic fault_in,
    // outputs
    output logic [10:0] setpoint_out_ff,
    output logic full_close_ff,
    output logic first_limit_alarm_ff,
    output logic second_limit_alarm_ff,
    output logic fault_alarm_ff,
    output logic maint_ff,
    output logic nv_save_ff,
    output logic [31:0] nv_total_ff,
    output logic irq_ff
);
    // a tick length that the 14-bit divider cannot count is refused at build time
    if (TICK_CYCLES < 2 || TICK_CYCLES > 16384) begin : g_tick_check
        $error("tick length does not fit the divider");
    end

    // the four single-bit pins besides fault_in pass two flip-flops; nothing but the second stage reads
    // the first, so a metastable sample never reaches the logic
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {power_fail_pin, solenoid_pin, failsafe_pin, cycle_done_pin};
            sync2_ff <= sync1_ff;
        end
    end
    wire cycle_lvl = sync2_ff[0];
    wire bypass = sync2_ff[1] | sync2_ff[2] | sync2_ff[3]; // R3

    // configuration registers
    // every field resets to a value in range, so the block runs unconfigured
    logic [7:0] ctrl_ff;
    logic [7:0] close_time_ff;
    logic [10:0] cutoff_ff;
    logic [10:0] lim1_ff;
    logic [10:0] lim2_ff;
    logic [31:0] total_limit_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic [31:0] total_ff;
    logic [9:0] save_cnt_ff;
    logic cycle_prev_ff;
    logic maint_prev_ff;
    logic fault_prev_ff;

    // one write strobe per writable register; an address that matches none is ignored
    wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wire wr_time = reg_wr && (reg_addr == OFS_CLOSE_TIME);
    wire wr_cut = reg_wr && (reg_addr == OFS_CUTOFF);
    wire wr_lim1 = reg_wr && (reg_addr == OFS_LIM1);
    wire wr_lim2 = reg_wr && (reg_addr == OFS_LIM2);
    wire wr_tlim = reg_wr && (reg_addr == OFS_TOTAL_LIMIT);
    wire wr_istat = reg_wr && (reg_addr == OFS_IRQ_STAT);
    wire wr_imask = reg_wr && (reg_addr == OFS_IRQ_MASK);
    // the clear choice is a write of one to bit 0 of the control word
    wire total_clear = wr_ctrl && reg_wdata[CTRL_CLEAR]; // R5

    // out-of-range writes are clamped to the allowed span; the whole word is
    // compared so that a large value can never wrap into a small one
    wire [7:0] time_w = (reg_wdata > 32'(CLOSE_TIME_MAX_S)) ? CLOSE_TIME_MAX_S
                                                            : reg_wdata[7:0];
    wire [10:0] cut_w = (reg_wdata > 32'(CUTOFF_MAX)) ? CUTOFF_MAX : reg_wdata[10:0];
    wire [10:0] lim1_w = (reg_wdata > 32'(RANGE_FULL)) ? RANGE_FULL : reg_wdata[10:0];
    wire [10:0] lim2_w = (reg_wdata > 32'(RANGE_FULL)) ? RANGE_FULL : reg_wdata[10:0];
    wire [31:0] tlim_lo = (reg_wdata < TOTAL_LIMIT_MIN) ? TOTAL_LIMIT_MIN : reg_wdata;
    wire [31:0] tlim_w = (tlim_lo > TOTAL_MAX) ? TOTAL_MAX : tlim_lo; // R7

    // control word, total limit and interrupt mask; the clear bit is a strobe
    // and is not stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= {2'h0, ALARM_MODE_RST, 4'hE};
            total_limit_ff <= TOTAL_LIMIT_RST;
            irq_mask_ff <= 3'h0;
        end else begin
            if (wr_ctrl) ctrl_ff <= {2'h0, reg_wdata[5:1], 1'b0};
            if (wr_tlim) total_limit_ff <= tlim_w; // R7
            if (wr_imask) irq_mask_ff <= reg_wdata[2:0];
        end
    end

    // ramp and limit settings, already clamped to their spans
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            close_time_ff <= CLOSE_TIME_RST;
            cutoff_ff <= CUTOFF_RST;
            lim1_ff <= LIM1_RST;
            lim2_ff <= LIM2_RST;
        end else begin
            if (wr_time) close_time_ff <= time_w; // R1
            if (wr_cut) cutoff_ff <= cut_w; // R13
            if (wr_lim1) lim1_ff <= lim1_w; // R11
            if (wr_lim2) lim2_ff <= lim2_w; // R12
        end
    end
    wire [1:0] alarm_mode = ctrl_ff[CTRL_MODE_LO +: 2];

    // tick divider for the ramp, 1 ms steps
    logic [13:0] div_ff;
    // free running, so the first tick of a ramp lands anywhere within one tick length of its start
    wire tick = (div_ff == 14'(TICK_CYCLES - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) div_ff <= 14'h0;
        else div_ff <= tick ? 14'h0 : div_ff + 14'h1;
    end

    // closing ramp: step accumulator in 1/ticks units of the range
    // fractional steps are kept so a long time still crosses the range exactly
    logic [17:0] frac_ff;
    wire [17:0] ticks_total = 18'(close_time_ff) * 18'(TICK_HZ); // R14
    wire [18:0] frac_sum = {1'b0, frac_ff} + 19'(RANGE_FULL);
    wire step_one = tick && (frac_sum >= {1'b0, ticks_total});
    // a trip drops the ramp at once so fail-safe venting is never held back
    wire ramp_off = (close_time_ff == 8'h00) || bypass; // R3 R14
    // only the closing direction is limited; a rise or hold passes in one cycle
    wire falling = setpoint_in < setpoint_out_ff;
    logic [10:0] nxt_sp;
    logic [17:0] nxt_frac;
    always_comb begin
        nxt_sp = setpoint_out_ff;
        nxt_frac = frac_ff;
        if (!falling || ramp_off) begin
            nxt_sp = setpoint_in; // R14
            nxt_frac = 18'h0;
        end else if (tick) begin // R1
            nxt_frac = step_one ? 18'(frac_sum - {1'b0, ticks_total}) : frac_sum[17:0];
            if (step_one) nxt_sp = setpoint_out_ff - 11'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setpoint_out_ff <= 11'h0;
            frac_ff <= 18'h0;
        end else begin
            setpoint_out_ff <= nxt_sp;
            frac_ff <= nxt_frac;
        end
    end

    // cutoff acts on the ramped set point so the ramp keeps priority; it lets go
    // again as soon as the ramped value climbs above the cutoff level
    wire cut_hit = ctrl_ff[CTRL_CUT_EN] && (setpoint_out_ff <= cutoff_ff); // R2 R13
    always_ff @(posedge clk or posedge rst) begin
        if (rst) full_close_ff <= 1'b0;
        else full_close_ff <= cut_hit; // R13
    end

    // travel cycle total, saturating at the top of its range instead of wrapping
    // to zero; a clear also restarts the save count, so saves stay on whole steps
    wire cycle_evt = cycle_lvl && !cycle_prev_ff;
    wire save_hit = cycle_evt && (save_cnt_ff == SAVE_EVERY - 10'h1);
    // a save that saturation or a clear holds back raises no event either
    wire save_evt = save_hit && (total_ff < TOTAL_MAX) && !total_clear;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            total_ff <= 32'h0; // R4
            save_cnt_ff <= 10'h0;
            cycle_prev_ff <= 1'b0;
        end else begin
            cycle_prev_ff <= cycle_lvl;
            if (total_clear) begin
                total_ff <= 32'h0; // R5
                save_cnt_ff <= 10'h0;
            end else if (cycle_evt && total_ff < TOTAL_MAX) begin
                total_ff <= total_ff + 32'h1; // R4
                save_cnt_ff <= save_hit ? 10'h0 : save_cnt_ff + 10'h1; // R6
            end
        end
    end

    // save strobe carries the new total to the non-volatile writer; the value
    // stands until the next save, so a slow writer may latch it late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nv_save_ff <= 1'b0;
            nv_total_ff <= 32'h0;
        end else begin
            nv_save_ff <= save_evt; // R6
            if (save_evt) nv_total_ff <= total_ff + 32'h1;
        end
    end

    // maintenance flag and limit alarms
    // the compare is strict, so the flag stays low with the total at the limit
    wire maint_now = total_ff > total_limit_ff; // R7
    // a disabled limit reads as not reached; its pin rests at the inactive level
    wire a1_raw = ctrl_ff[CTRL_LIM1_EN] && (position_in < lim1_ff); // R11
    wire a2_raw = ctrl_ff[CTRL_LIM2_EN] && (position_in < lim2_ff); // R12
    // mode bit0 set inverts the first alarm, bit1 clear the second, so the default mode
    // gives both alarms the high-current level when active
    wire a1_lvl = alarm_mode[0] ? !a1_raw : a1_raw; // R8 R9
    wire a2_lvl = alarm_mode[1] ? a2_raw : !a2_raw; // R8 R9
    // the fault output rests conducting and opens on a fault, so a cut wire
    // reads as a fault as well
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            maint_ff <= 1'b0;
            first_limit_alarm_ff <= 1'b0;
            second_limit_alarm_ff <= 1'b0;
            fault_alarm_ff <= 1'b0;
        end else begin
            maint_ff <= maint_now; // R7
            first_limit_alarm_ff <= a1_lvl; // R8
            second_limit_alarm_ff <= a2_lvl; // R8
            fault_alarm_ff <= !fault_in; // R10
        end
    end

    // last levels of the event sources, for the rising-edge events below
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            maint_prev_ff <= 1'b0;
            fault_prev_ff <= 1'b0;
        end else begin
            maint_prev_ff <= maint_now;
            fault_prev_ff <= fault_in;
        end
    end

    // sticky events; a set in the clearing cycle wins so no event is ever lost
    wire [2:0] irq_set = {fault_in && !fault_prev_ff, maint_now && !maint_prev_ff, save_evt};
    wire [2:0] irq_clr = wr_istat ? reg_wdata[2:0] : 3'h0;
    // the interrupt follows the next status value, so it rises with the event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
        end
    end

    // read mux; unmapped addresses read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (reg_addr)
            OFS_CTRL: rd_mux = {24'h0, ctrl_ff};
            OFS_CLOSE_TIME: rd_mux = {24'h0, close_time_ff};
            OFS_CUTOFF: rd_mux = {21'h0, cutoff_ff};
            OFS_LIM1: rd_mux = {21'h0, lim1_ff};
            OFS_LIM2: rd_mux = {21'h0, lim2_ff};
            OFS_TOTAL: rd_mux = total_ff;
            OFS_TOTAL_LIMIT: rd_mux = total_limit_ff;
            OFS_STATUS: rd_mux = {26'h0, bypass, fault_alarm_ff, second_limit_alarm_ff,
                                  first_limit_alarm_ff, full_close_ff, maint_ff};
            OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
            OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
            OFS_SETPOINT: rd_mux = {21'h0, setpoint_out_ff};
            default: rd_mux = 32'h0;
        endcase
    end
    // read data are zero outside the answer cycle, so slaves can share an OR bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) reg_rdata_ff <= 32'h0;
        else reg_rdata_ff <= reg_rd ? rd_mux : 32'h0;
    end
endmodule : vrt_core
`default_nettype wire

// [dv/vrt_core_sva.sv]
// Purpose: port checks for the closing ramp, travel total and alarm block
// Assumes: single clock, reset active high
// Notes: register-dependent figures are left to the bench
`timescale 1ns/1ns
`default_nettype none
module vrt_core_chk
    import vrt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    // process side
    input wire logic [10:0] setpoint_in,
    input wire logic failsafe_pin,
    input wire logic solenoid_pin,
    input wire logic power_fail_pin,
    input wire logic fault_in,
    // outputs
    input wire logic [10:0] setpoint_out_ff,
    input wire logic full_close_ff,
    input wire logic fault_alarm_ff,
    input wire logic nv_save_ff,
    input wire logic [31:0] nv_total_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // four samples so the two-flop sync has landed
    sequence s_bypass; (failsafe_pin || solenoid_pin || power_fail_pin) [*4]; endsequence
    sequence s_ctrl_rd; reg_rd && reg_addr == OFS_CTRL; endsequence
    property p_clear_rd; s_ctrl_rd |=> reg_rdata_ff[CTRL_CLEAR] == 1'b0; endproperty
    a_clear_rd: assert property (p_clear_rd) else $error("clear bit reads one");
    // first edge after reset is skipped, the output lags one cycle
    property p_fault; !$past(rst) |-> fault_alarm_ff == !$past(fault_in); endproperty
    a_fault: assert property (p_fault) else $error("fault alarm level wrong");
    property p_rise; setpoint_in >= setpoint_out_ff |=> setpoint_out_ff == $past(setpoint_in); endproperty
    a_rise: assert property (p_rise) else $error("rising set point held back");
    property p_bypass; s_bypass |=> setpoint_out_ff == $past(setpoint_in); endproperty
    a_bypass: assert property (p_bypass) else $error("ramp not bypassed");
    property p_cut; full_close_ff |-> $past(setpoint_out_ff) <= CUTOFF_MAX; endproperty
    a_cut: assert property (p_cut) else $error("full close above cutoff range");
    property p_save_gap; nv_save_ff |=> !nv_save_ff [*8]; endproperty
    a_save_gap: assert property (p_save_gap) else $error("save pulse too long");
    property p_save_val; nv_save_ff |-> nv_total_ff % {22'h000, SAVE_EVERY} == 32'h0; endproperty
    a_save_val: assert property (p_save_val) else $error("saved total not a step");
    property p_save_max; nv_save_ff |-> nv_total_ff <= TOTAL_MAX && nv_total_ff != 32'h0; endproperty
    a_save_max: assert property (p_save_max) else $error("saved total out of range");
endmodule : vrt_core_chk
bind vrt_core vrt_core_chk i_chk (.clk, .rst, .reg_addr, .reg_rd, .reg_rdata_ff, .setpoint_in,
    .failsafe_pin, .solenoid_pin, .power_fail_pin, .fault_in, .setpoint_out_ff, .full_close_ff,
    .fault_alarm_ff, .nv_save_ff, .nv_total_ff);
`default_nettype wire

// [dv/vrt_core_bench.sv]
// Purpose: self-checking run of ramp, travel total, alarms and interrupts
// Assumes: 10 MHz clock, positions in 0.1 % steps
// Notes: the ramp is watched over three ticks only to keep the run short
`timescale 1ns/1ns
`default_nettype none
module vrt_core_bench
    import vrt_pkg::*;
;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cycle_done_pin = 0, fault_in = 0;
    logic failsafe_pin = 0, solenoid_pin = 0, power_fail_pin = 0, full_close_ff, maint_ff;
    logic first_limit_alarm_ff, second_limit_alarm_ff, fault_alarm_ff, nv_save_ff, irq_ff;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_ff, nv_total_ff, rv;
    logic [10:0] setpoint_in = 11'h000, position_in = 11'h1F4, setpoint_out_ff;
    int bad_count = 0, checked = 0, saves = 0;
    logic [7:0] ra [8] = '{OFS_CTRL, OFS_CLOSE_TIME, OFS_CUTOFF, OFS_LIM1, OFS_LIM2, OFS_TOTAL,
        OFS_TOTAL_LIMIT, 8'h40};
    logic [31:0] re [8] = '{32'h2E, 32'(CLOSE_TIME_RST), 32'(CUTOFF_RST), 32'(LIM1_RST),
        32'(LIM2_RST), 32'h0, TOTAL_LIMIT_RST, 32'h0};
    vrt_core i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
        .setpoint_in, .position_in, .cycle_done_pin, .failsafe_pin, .solenoid_pin,
        .power_fail_pin, .fault_in, .setpoint_out_ff, .full_close_ff, .first_limit_alarm_ff,
        .second_limit_alarm_ff, .fault_alarm_ff, .maint_ff, .nv_save_ff, .nv_total_ff, .irq_ff);
    // clock and save pulse counter
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (nv_save_ff === 1'b1) saves++;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    // one settled sample point, a nanosecond past the edge
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata_ff);
    endtask : rchk
    task pulses(input int n);
        repeat (n) begin
            @(posedge clk) cycle_done_pin <= 1'b1;
            tick(2);
            @(posedge clk) cycle_done_pin <= 1'b0;
            tick(2);
        end
        tick(4);
    endtask : pulses
    task close_out;
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // watchdog, the tests need about 36000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        close_out();
    end
    initial begin
        tick(12);
        @(posedge clk) rst <= 1'b0;
        tick(2);
        for (int i = 0; i < 8; i++) rchk("reset", ra[i], re[i]);
        wr(OFS_TOTAL_LIMIT, 32'h5);
        wr(8'h40, 32'hFF);
        rchk("limit", OFS_TOTAL_LIMIT, TOTAL_LIMIT_MIN);
        rchk("unmapped", 8'h40, 32'h0);
        wr(OFS_CLOSE_TIME, 32'h100);
        rchk("time clamp", OFS_CLOSE_TIME, 32'(CLOSE_TIME_MAX_S));
        // polarity per mode, below first limit then above second
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 32'h0E | (m << 4));
            @(posedge clk) position_in <= 11'h00A;
            tick(3);
            chk("a1", !m[0], first_limit_alarm_ff);
            chk("a2", m[1], second_limit_alarm_ff);
            @(posedge clk) position_in <= 11'h3E8;
            tick(3);
            chk("a1", m[0], first_limit_alarm_ff);
            chk("a2", !m[1], second_limit_alarm_ff);
        end
        wr(OFS_CTRL, 32'h2A);
        @(posedge clk) position_in <= 11'h00A;
        tick(3);
        chk("a1 off", 0, first_limit_alarm_ff);
        wr(OFS_CTRL, 32'h26);
        tick(3);
        chk("a2 off", 0, second_limit_alarm_ff);
        // fault alarm raises its masked-in interrupt, cleared by write one
        wr(OFS_IRQ_MASK, 32'h1 << IRQ_FAULT);
        @(posedge clk) fault_in <= 1'b1;
        tick(3);
        chk("fault", 0, fault_alarm_ff);
        @(posedge clk) fault_in <= 1'b0;
        tick(3);
        chk("fault", 1, fault_alarm_ff);
        chk("irq", 1, irq_ff);
        wr(OFS_IRQ_STAT, 32'h1 << IRQ_FAULT);
        tick(2);
        chk("irq", 0, irq_ff);
        // total reaches the limit, then passes it; save and maint events stay masked
        pulses(1000);
        chk("maint", 0, maint_ff);
        chk("saves", 1, saves);
        chk("nv total", 32'h3E8, nv_total_ff);
        pulses(1);
        chk("maint", 1, maint_ff);
        rchk("total", OFS_TOTAL, 32'h3E9);
        chk("saves", 1, saves);
        chk("irq", 0, irq_ff);
        rchk("irq stat", OFS_IRQ_STAT, (32'h1 << IRQ_SAVE) | (32'h1 << IRQ_MAINT));
        wr(OFS_CTRL, 32'h2F);
        tick(2);
        rchk("total", OFS_TOTAL, 32'h0);
        chk("maint", 0, maint_ff);
        // one second over the range gives one step per millisecond tick
        wr(OFS_CLOSE_TIME, 32'h1);
        @(posedge clk) setpoint_in <= 11'h3E8;
        tick(3);
        chk("rise", 11'h3E8, setpoint_out_ff);
        @(posedge clk) setpoint_in <= 11'h000;
        tick(30000);
        chk("ramp", 1, setpoint_out_ff inside {11'h3E4, 11'h3E5, 11'h3E6});
        chk("cut", 0, full_close_ff);
        @(posedge clk) failsafe_pin <= 1'b1;
        tick(6);
        chk("bypass", 0, setpoint_out_ff);
        chk("cut", 1, full_close_ff);
        @(posedge clk) failsafe_pin <= 1'b0;
        wr(OFS_CLOSE_TIME, 32'h0);
        @(posedge clk) setpoint_in <= 11'h3E8;
        tick(6);
        @(posedge clk) setpoint_in <= 11'h000;
        tick(3);
        chk("no ramp", 0, setpoint_out_ff);
        close_out();
    end
endmodule : vrt_core_bench
`default_nettype wire
